// ---- common/usp_pkg.sv ----
// Purpose: shared constants of the side pin port (map, fields, modes, reset values)
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes: registers hold six bits (mode four) in byte lane 0, upper bits read as zero
package usp_pkg;
	localparam int NUM_PINS = 6;
	localparam int ADDR_W   = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_DIR   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_HIGH  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LOW   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MODE  = 8'h10;

	// register select codes used by the address decoder
	localparam logic [2:0] SEL_NONE  = 3'h0;
	localparam logic [2:0] SEL_DIR   = 3'h1;
	localparam logic [2:0] SEL_HIGH  = 3'h2;
	localparam logic [2:0] SEL_LOW   = 3'h3;
	localparam logic [2:0] SEL_LEVEL = 3'h4;
	localparam logic [2:0] SEL_MODE  = 3'h5;

	// mode register fields
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_SEL_W   = 3;
	localparam int MODE_POL_BIT = 3;

	// line takeover modes
	localparam logic [2:0] MODE_GPIO   = 3'h0;
	localparam logic [2:0] MODE_RTSCTS = 3'h1;
	localparam logic [2:0] MODE_DTRDSR = 3'h2;
	localparam logic [2:0] MODE_MDXCVR = 3'h3;
	localparam logic [2:0] MODE_MDTXEN = 3'h4;

	// pins taken over by the modes
	localparam int PIN_CTS  = 4;
	localparam int PIN_RTS  = 5;
	localparam int PIN_DSR  = 2;
	localparam int PIN_DTR  = 3;
	localparam int PIN_XCVR = 5;

	// reset values
	localparam logic [5:0] RST_DIR  = 6'h00;
	localparam logic [5:0] RST_OUT  = 6'h00;
	localparam logic [3:0] RST_MODE = 4'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/usp_axil_slave.sv ----
// Purpose: AXI4-Lite slave front end handing out one-cycle write and read strobes
// Assumes: one write and one read under way at a time, same clock as the port
// Notes: address and data may arrive in either order; the write strobe fires once both are held
`timescale 1ns/10ps
`default_nettype none
module usp_axil_slave
	import usp_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output var  logic          awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output var  logic          wready,
	output var  logic [1:0]    bresp,
	output var  logic          bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output var  logic          arready,
	output var  logic [31:0]   rdata,
	output var  logic [1:0]    rresp,
	output var  logic          rvalid,
	input  wire logic          rready,
	output var  logic          wr_fire,
	output var  logic [AW-1:0] wr_addr,
	output var  logic [31:0]   wr_data,
	output var  logic [3:0]    wr_strb,
	input  wire logic          wr_err,
	output var  logic          rd_fire,
	output var  logic [AW-1:0] rd_addr,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_err
);
	logic aw_hold_q;
	logic w_hold_q;
	logic aw_hold_d;
	logic w_hold_d;
	logic rvalid_d;
	logic aw_take;
	logic w_take;

	// handshakes and hold flags; ready is the inverse of the hold
	assign aw_take   = awvalid & awready;
	assign w_take    = wvalid & wready;
	assign wr_fire   = aw_hold_q & w_hold_q & ~bvalid;
	assign aw_hold_d = wr_fire ? 1'b0 : (aw_take | aw_hold_q);
	assign w_hold_d  = wr_fire ? 1'b0 : (w_take | w_hold_q);
	assign rd_fire   = arvalid & arready;
	assign rd_addr   = araddr;
	assign rvalid_d  = rd_fire | (rvalid & ~rready);

	// write channel state
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			wr_addr   <= '0;
			wr_data   <= '0;
			wr_strb   <= '0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awready   <= ~aw_hold_d;
			wready    <= ~w_hold_d;
			if (aw_take) begin
				wr_addr <= awaddr;
			end
			if (w_take) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel: data captured at the address handshake, so no extra cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= ~rvalid_d;
			rvalid  <= rvalid_d;
			if (rd_fire) begin
				rdata <= rd_data;
				rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
endmodule // usp_axil_slave
`default_nettype wire

// ---- verilog/usp_pin_port.sv ----
// Purpose: six-line general-purpose pin port with set/clear drive and live level readback
// Assumes: flow-control and transceiver signals come from the serial core on CLK_SYS
// Notes: pins are sampled through three flops; outputs change one cycle after the register
//
// Notes on behaviour
// RULE1 - direction bit zero makes its pin an input, one makes it an output
// RULE2 - a one written to the drive-high register sets that output; zeros change nothing
// RULE3 - a one written to the drive-low register clears that output; zeros change nothing
// RULE4 - reading the level register returns the present level of every pin
// RULE5 - software writes zeros to upper bits seven and six of those registers
// RULE6 - direction applies only to pins the selected mode has not taken over
// RULE7 - mode 001 turns pin 4 into clear-to-send input, pin 5 request-to-send output
// RULE8 - mode 010 turns pin 2 into data-set-ready input, pin 3 data-terminal-ready output
// RULE9 - reading the level register never alters pins, directions or output values
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module usp_pin_port
	import usp_pkg::*;
#(
	parameter int NPINS = NUM_PINS
) (
	input  wire logic              CLK_SYS,
	input  wire logic              RST,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output var  logic              S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output var  logic              S_AXI_WREADY,
	output var  logic [1:0]        S_AXI_BRESP,
	output var  logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output var  logic              S_AXI_ARREADY,
	output var  logic [31:0]       S_AXI_RDATA,
	output var  logic [1:0]        S_AXI_RRESP,
	output var  logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic [NPINS-1:0]  PORT_PIN_IN,
	output var  logic [NPINS-1:0]  PORT_PIN_OUT,
	output var  logic [NPINS-1:0]  PORT_PIN_OE,
	input  wire logic              FLOW_RTS_N,
	input  wire logic              FLOW_DTR_N,
	input  wire logic              FLOW_TX_ACTIVE,
	output var  logic              FLOW_CTS_N,
	output var  logic              FLOW_DSR_N
);
	// the mode takeover map is fixed to six lines
	if (NPINS != NUM_PINS) begin : g_bad_width
		$error("usp_pin_port supports exactly six pins");
	end

	logic [NPINS-1:0]  dir_q;
	logic [NPINS-1:0]  dir_d;
	logic [NPINS-1:0]  out_q;
	logic [NPINS-1:0]  out_d;
	logic [3:0]        mode_q;
	logic [3:0]        mode_d;
	logic [NPINS-1:0]  sync1_q;
	logic [NPINS-1:0]  sync2_q;
	logic [NPINS-1:0]  sync3_q;
	logic [NPINS-1:0]  level_q;
	logic [NPINS-1:0]  level_d;
	logic [NPINS-1:0]  claim;
	logic [NPINS-1:0]  func_oe;
	logic [NPINS-1:0]  func_val;
	logic [NPINS-1:0]  pin_out_d;
	logic [NPINS-1:0]  pin_oe_d;
	logic [2:0]        mode_sel;
	logic              xcvr_level;
	logic              wr_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              rd_fire;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic [2:0]        wr_sel;
	logic [2:0]        rd_sel;
	logic              wr_lane0;
	logic [NPINS-1:0]  wr_bits;

	// map a byte address onto a register select code
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
		if (addr == OFS_DIR) begin
			return SEL_DIR;
		end else if (addr == OFS_HIGH) begin
			return SEL_HIGH;
		end else if (addr == OFS_LOW) begin
			return SEL_LOW;
		end else if (addr == OFS_LEVEL) begin
			return SEL_LEVEL;
		end else if (addr == OFS_MODE) begin
			return SEL_MODE;
		end else begin
			return SEL_NONE;
		end
	endfunction

	// lines that a mode takes away from the direction register
	function automatic logic [NUM_PINS-1:0] mode_claim(input logic [2:0] sel);
		logic [NUM_PINS-1:0] m;
		m = '0;
		case (sel)
			MODE_RTSCTS: begin
				m[PIN_CTS] = 1'b1;
				m[PIN_RTS] = 1'b1;
			end
			MODE_DTRDSR: begin
				m[PIN_DSR] = 1'b1;
				m[PIN_DTR] = 1'b1;
			end
			MODE_MDXCVR, MODE_MDTXEN: begin
				m[PIN_XCVR] = 1'b1;
			end
			default: begin
				m = '0;
			end
		endcase
		return m;
	endfunction

	// bus front end
	usp_axil_slave #(
		.AW (ADDR_W)
	) u_bus (
		.clk     (CLK_SYS),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.wr_fire (wr_fire),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_sel == SEL_NONE || wr_sel == SEL_LEVEL),
		.rd_fire (rd_fire),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_sel == SEL_NONE)
	);

	// write decode; upper lanes are ignored since every register is one byte
	assign wr_sel   = reg_sel(wr_addr);
	assign rd_sel   = reg_sel(rd_addr);
	assign wr_lane0 = wr_fire & wr_strb[0];
	assign wr_bits  = wr_data[NPINS-1:0]; // bits 7:6 dropped, software keeps them zero (see RULE5)

	// register next values
	assign dir_d  = (wr_lane0 && wr_sel == SEL_DIR) ? wr_bits : dir_q; // see RULE1
	assign mode_d = (wr_lane0 && wr_sel == SEL_MODE) ? wr_data[3:0] : mode_q;
	assign out_d  = (wr_lane0 && wr_sel == SEL_HIGH) ? (out_q | wr_bits) :   // see RULE2
	                (wr_lane0 && wr_sel == SEL_LOW)  ? (out_q & ~wr_bits) :  // see RULE3
	                out_q;

	// readback is a pure mux: no read strobe reaches any register (see RULE9)
	assign rd_data = (rd_sel == SEL_DIR)   ? {{(32-NPINS){1'b0}}, dir_q} :
	                 (rd_sel == SEL_HIGH)  ? {{(32-NPINS){1'b0}}, out_q} :
	                 (rd_sel == SEL_LOW)   ? {{(32-NPINS){1'b0}}, out_q} :
	                 (rd_sel == SEL_LEVEL) ? {{(32-NPINS){1'b0}}, level_q} : // see RULE4
	                 (rd_sel == SEL_MODE)  ? {28'h0000000, mode_q} :
	                 32'h00000000;

	// control registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dir_q  <= RST_DIR;
			out_q  <= RST_OUT;
			mode_q <= RST_MODE;
		end else begin
			dir_q  <= dir_d;
			out_q  <= out_d;
			mode_q <= mode_d;
		end
	end

	// pin synchroniser; a change counts only once stages two and three agree
	assign level_d = (sync2_q & sync3_q) | (level_q & (sync2_q ^ sync3_q)); // per line (see RULE4)
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			level_q <= '0;
		end else begin
			sync1_q <= PORT_PIN_IN;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			level_q <= level_d;
		end
	end

	// takeover map; the transceiver enable follows the transmit flag, inverted unless the polarity bit is set
	assign mode_sel   = mode_q[MODE_SEL_LSB +: MODE_SEL_W];
	assign claim      = mode_claim(mode_sel); // see RULE6
	assign xcvr_level = mode_q[MODE_POL_BIT] ? FLOW_TX_ACTIVE : ~FLOW_TX_ACTIVE;

	// function-side direction and value of each claimed line
	always_comb begin
		func_oe  = '0;
		func_val = '0;
		case (mode_sel)
			MODE_RTSCTS: begin
				func_oe[PIN_RTS]  = 1'b1;       // see RULE7
				func_val[PIN_RTS] = FLOW_RTS_N; // see RULE7
			end
			MODE_DTRDSR: begin
				func_oe[PIN_DTR]  = 1'b1;       // see RULE8
				func_val[PIN_DTR] = FLOW_DTR_N; // see RULE8
			end
			MODE_MDXCVR, MODE_MDTXEN: begin
				func_oe[PIN_XCVR]  = 1'b1;
				func_val[PIN_XCVR] = xcvr_level;
			end
			default: begin
				func_oe  = '0;
				func_val = '0;
			end
		endcase
	end

	// per-line selection between function and general-purpose drive
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		assign pin_oe_d[i]  = claim[i] ? func_oe[i] : dir_q[i];  // see RULE1, see RULE6
		assign pin_out_d[i] = claim[i] ? func_val[i] : out_q[i]; // see RULE2, see RULE3
	end

	// pins and handshake inputs registered; unused handshakes idle high (inactive)
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PORT_PIN_OE  <= '0;
			PORT_PIN_OUT <= '0;
			FLOW_CTS_N   <= 1'b1;
			FLOW_DSR_N   <= 1'b1;
		end else begin
			PORT_PIN_OE  <= pin_oe_d;
			PORT_PIN_OUT <= pin_out_d;
			FLOW_CTS_N   <= (mode_sel == MODE_RTSCTS) ? level_q[PIN_CTS] : 1'b1; // see RULE7
			FLOW_DSR_N   <= (mode_sel == MODE_DTRDSR) ? level_q[PIN_DSR] : 1'b1; // see RULE8
		end
	end

	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_pin_steady;
		$stable(PORT_PIN_IN) [*4];
	endsequence

	sequence s_drive_write(logic [2:0] sel);
		wr_lane0 && wr_sel == sel;
	endsequence

	chk_dir_gpio_oe: // see RULE1
	assert property (1'b1 |=> ((PORT_PIN_OE ^ $past(dir_q)) & ~$past(claim)) == '0)
		else $error("gpio line enable differs from direction bit");

	chk_set_drive: // see RULE2
	assert property (s_drive_write(SEL_HIGH) |=>
		((out_q & $past(wr_bits)) == $past(wr_bits)) &&
		(((out_q ^ $past(out_q)) & ~$past(wr_bits)) == '0))
		else $error("drive-high write set wrong bits");

	chk_clear_drive: // see RULE3
	assert property (s_drive_write(SEL_LOW) |=>
		((out_q & $past(wr_bits)) == '0) &&
		(((out_q ^ $past(out_q)) & ~$past(wr_bits)) == '0))
		else $error("drive-low write cleared wrong bits");

	chk_gpio_value: // see RULE2
	assert property (1'b1 |=> ((PORT_PIN_OUT ^ $past(out_q)) & ~$past(claim)) == '0)
		else $error("gpio line value differs from output latch");

	chk_level_sync: // see RULE4
	assert property (s_pin_steady |=> level_q == $past(PORT_PIN_IN))
		else $error("steady pin level not reflected");

	chk_level_read: // see RULE4
	assert property (rd_fire && rd_sel == SEL_LEVEL |=>
		S_AXI_RVALID && S_AXI_RDATA == {26'h0, $past(level_q)})
		else $error("level readback wrong");

	chk_claim_oe: // see RULE6
	assert property (1'b1 |=> ((PORT_PIN_OE ^ $past(func_oe)) & $past(claim)) == '0)
		else $error("claimed line ignores its function direction");

	chk_rts_cts: // see RULE7
	assert property (mode_sel == MODE_RTSCTS |=> PORT_PIN_OE[PIN_RTS] && !PORT_PIN_OE[PIN_CTS]
		&& PORT_PIN_OUT[PIN_RTS] == $past(FLOW_RTS_N) && FLOW_CTS_N == $past(level_q[PIN_CTS]))
		else $error("rts/cts takeover wrong");

	chk_dtr_dsr: // see RULE8
	assert property (mode_sel == MODE_DTRDSR |=> PORT_PIN_OE[PIN_DTR] && !PORT_PIN_OE[PIN_DSR]
		&& PORT_PIN_OUT[PIN_DTR] == $past(FLOW_DTR_N) && FLOW_DSR_N == $past(level_q[PIN_DSR]))
		else $error("dtr/dsr takeover wrong");

	chk_read_quiet: // see RULE9
	assert property (rd_fire && !wr_fire |=> $stable(out_q) && $stable(dir_q) && $stable(mode_q))
		else $error("read altered port state");
endmodule // usp_pin_port
`default_nettype wire

// ---- verification/usp_board_model.sv ----
// Purpose: board logic wired to the six port lines
// Assumes: the board drives every line that the port leaves undriven
// Notes: driven lines show the port's value, so a read of the level sees it
`timescale 1ns/10ps
`default_nettype none
module usp_board_model (
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	input  wire logic [5:0] board_drive,
	output var  logic [5:0] pin_level
);
	// wire level from the port's enable alone, the board drives every other line, no contention modelled
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_drive);
endmodule // usp_board_model
`default_nettype wire

// ---- verification/tb_uart_side_pin_port.sv ----
// Purpose: self-checking bench of the side pin port
// Assumes: reads answer after the address is taken, pins settle within six cycles
// Notes: read results go through a queue, compared by a monitor at the falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_uart_side_pin_port;
	import usp_pkg::*;
	logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rdata;
	logic [1:0]  bresp, rresp;
	logic        awr, wr_rdy, bv, arr, rv, cts_n, dsr_n, rts = 1, dtr = 1, tx = 0;
	logic [5:0]  pin_in, pin_out, pin_oe, ext = 0, dir, out, e;
	logic [33:0] q[$];
	logic [31:0] r;
	logic [3:0]  m;
	int          mismatches = 0, checked = 0, cycles = 0, seed = 57464, i;

	// clock at 250 MHz
	always #2 clk = ~clk;

	usp_pin_port dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .PORT_PIN_IN(pin_in),
		.PORT_PIN_OUT(pin_out), .PORT_PIN_OE(pin_oe), .FLOW_RTS_N(rts), .FLOW_DTR_N(dtr),
		.FLOW_TX_ACTIVE(tx), .FLOW_CTS_N(cts_n), .FLOW_DSR_N(dsr_n));

	usp_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .board_drive(ext),
		.pin_level(pin_in));

	task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask

	// wait n edges, then look at settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// ready sampled at the falling edge holds until the rising edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		logic [1:0] br;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		do begin
			@(negedge clk);
			ta = awv & awr; tw = wv & wr_rdy; tb = bv;
			br = bresp;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			if (tb) bre <= 0;
		end while (!tb);
		// level register and unmapped words refuse writes
		chk("bresp", (a == OFS_LEVEL || a > OFS_MODE || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY, br);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] rs);
		logic ta, tr;
		q.push_back({rs, x});
		@(posedge clk);
		ara <= a; arv <= 1; rre <= 1;
		do begin
			@(negedge clk);
			ta = arv & arr; tr = rv;
			@(posedge clk);
			if (ta) arv <= 0;
			if (tr) rre <= 0;
		end while (!tr);
	endtask

	// monitor: each answered read takes the oldest note
	always @(negedge clk) begin
		if (rv === 1'b1 && rre) begin
			if (q.size() == 0) chk("read queue", 34'h1, 34'h0);
			else chk("read", q.pop_front(), {rresp, rdata});
		end
	end

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// hang guard, the run needs well under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			finish_test();
		end
	end

	initial begin
		out = 0;
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(OFS_DIR, 32'h0, RESP_OKAY);
		rd(OFS_LEVEL, 32'h0, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(OFS_LEVEL, 32'h3f);
		rd(OFS_LEVEL, 32'h0, RESP_OKAY);
		// random direction, set and clear masks; upper bits always written zero
		for (i = 0; i < 6; i++) begin
			r = $random(seed);
			dir = r[5:0];
			e = r[29:24];
			wr(OFS_DIR, {26'h0, dir});
			wr(OFS_HIGH, {26'h0, r[13:8]});
			out = out | r[13:8];
			wr(OFS_LOW, {26'h0, r[21:16]});
			out = out & ~r[21:16];
			ext <= e;
			wt(6);
			chk("oe", dir, pin_oe);
			chk("out", out & dir, pin_out & dir);
			rd(OFS_DIR, {26'h0, dir}, RESP_OKAY);
			rd(OFS_LEVEL, {26'h0, (dir & out) | (~dir & e)}, RESP_OKAY);
			rd(OFS_LEVEL, {26'h0, (dir & out) | (~dir & e)}, RESP_OKAY);
			wt(1);
			chk("oe after read", dir, pin_oe);
			chk("out after read", out & dir, pin_out & dir);
		end
		// flow-control modes take lines over whatever the direction says
		wr(OFS_DIR, 32'h3f);
		for (m = 1; m < 3; m++) begin
			r = $random(seed);
			e = r[5:0];
			wr(OFS_MODE, {28'h0, m});
			rts <= r[8];
			dtr <= r[9];
			ext <= e;
			wt(6);
			chk("mode oe", (m == 1) ? 6'h2f : 6'h3b, pin_oe);
			if (m == 1) begin
				chk("rts line", r[8], pin_out[PIN_RTS]);
				chk("cts", e[PIN_CTS], cts_n);
			end else begin
				chk("dtr line", r[9], pin_out[PIN_DTR]);
				chk("dsr", e[PIN_DSR], dsr_n);
			end
		end
		// transceiver modes: line five follows the transmit flag, bit 3 picks its polarity
		for (i = 0; i < 2; i++) begin
			wr(OFS_MODE, (i == 1) ? 32'hc : 32'h3);
			tx <= 1'b1;
			wt(2);
			chk("xcvr oe", 6'h3f, pin_oe);
			chk("xcvr busy", (i == 1), pin_out[PIN_XCVR]);
			@(posedge clk);
			tx <= 1'b0;
			wt(2);
			chk("xcvr idle", (i == 0), pin_out[PIN_XCVR]);
			rd(OFS_MODE, (i == 1) ? 32'hc : 32'h3, RESP_OKAY);
		end
		wr(OFS_MODE, 32'h0);
		wt(6);
		chk("gpio oe", 6'h3f, pin_oe);
		chk("cts idle", 1'b1, cts_n);
		wt(2);
		finish_test();
	end
endmodule // tb_uart_side_pin_port
`default_nettype wire
